/* logic/gesture_engine_defines.svh */
// Register map, field layout, reset values and timing for the gesture configuration block
`ifndef GESTURE_ENGINE_DEFINES_SVH
`define GESTURE_ENGINE_DEFINES_SVH

`define ADDR_EXIT_PERS   8'h00
`define ADDR_WAIT_CFG    8'h04
`define ADDR_NORTH_OFS   8'h08
`define ADDR_CONTROL     8'h0C
`define ADDR_STATUS      8'h10

`define EXIT_PERS_MSB    1
`define EXIT_PERS_LSB    0
`define ENTER_ALWAYS_BIT 7
`define GAIN_MSB         6
`define GAIN_LSB         5
`define LED_MSB          4
`define LED_LSB          3
`define WAIT_MSB         2
`define WAIT_LSB         0
`define CTRL_EN_BIT      0
`define CTRL_THR_MSB     15
`define CTRL_THR_LSB     8

`define RST_EXIT_PERS    2'h0
`define RST_WAIT_CFG     8'h00
`define RST_NORTH_OFS    8'h00
`define RST_THRESHOLD    8'h00

`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

`define CLK_PERIOD_NS    20
`define WAIT_UNIT_US     2800
`define WAIT_UNIT_CYC    ((`WAIT_UNIT_US * 1000) / `CLK_PERIOD_NS)
`define LED_TAIL_NS      1330
`define LED_TAIL_CYC     ((`LED_TAIL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* logic/gesture_engine_pkg.sv */
// Types shared by the gesture configuration block
package gesture_engine_pkg;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_CYCLE = 3'b010,
        ST_WAIT  = 3'b100
    } gest_state_t;
endpackage : gesture_engine_pkg

/* logic/gesture_wait_timer.sv */
// Low-power wait timer between gesture detection cycles
`timescale 1ns/1ps
`include "gesture_engine_defines.svh"
module gesture_wait_timer #(
    parameter int unsigned UNIT_CYCLES = `WAIT_UNIT_CYC
) (
    // Clock and reset
    input  wire logic       aclk,
    input  wire logic       aresetn,
    // Control
    input  wire logic       start,
    input  wire logic [2:0] code,
    // Status
    output logic            busy,
    output logic            done
);
    logic [31:0] cnt_q;

    // All wait times are whole multiples of the 2.8 ms unit
    function automatic logic [3:0] wait_units(input logic [2:0] c);
        case (c)
            3'h0: wait_units = 4'h0;
            3'h1: wait_units = 4'h1;
            3'h2: wait_units = 4'h2;
            3'h3: wait_units = 4'h3;
            3'h4: wait_units = 4'h5;
            3'h5: wait_units = 4'h8;
            3'h6: wait_units = 4'hB;
            default: wait_units = 4'hE;
        endcase
    endfunction : wait_units

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 32'h0;
        end else if (start) begin
            cnt_q <= 32'(wait_units(code)) * 32'(UNIT_CYCLES);
        end else if (cnt_q != 32'h0) begin
            cnt_q <= cnt_q - 32'h1;
        end
    end

    assign busy = (cnt_q != 32'h0);
    // Code zero finishes in the start cycle; a stale count left from a disable must not end a new wait
    assign done = start ? (wait_units(code) == 4'h0) : (cnt_q == 32'h1);
endmodule : gesture_wait_timer

/* logic/gesture_engine_config.sv */
// Gesture engine configuration, entry/exit control and AXI4-Lite register slave
// How it works
// [R01] Exit after persistence-selected consecutive gesture ends; count clears in ST_WAIT, so with a nonzero wait only persistence 0 exits
// [R02] Non-end cycle clears the end count
// [R03] Enter-always enters on any proximity result
// [R04] Otherwise enter only when threshold is met
// [R05] Gain field decodes to 1x/2x/4x/8x
// [R06] LED field decodes to 100/50/25/12.5%
// [R07] Wait field selects 0 to 39.2 ms
// [R08] Software sets wait time before enable
// [R09] LED stays on 1.33 us past integration
// [R10] North offset is sign and magnitude
//
// Implementation choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "gesture_engine_defines.svh"
module gesture_engine_config #(
    parameter int unsigned WAIT_UNIT_CYCLES = `WAIT_UNIT_CYC
) (
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write
    input  wire logic [7:0]        awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [7:0]        araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Engine inputs
    input  wire logic [7:0]        proximity_result,
    input  wire logic              prox_valid,
    input  wire logic              cycle_done,
    input  wire logic              gesture_end_det,
    input  wire logic              integration_active,
    // Engine outputs
    output logic                   in_gesture,
    output logic                   cycle_start,
    output logic                   wait_active,
    output logic                   led_on,
    output logic [3:0]             photodiode_gain,
    output logic [3:0]             led_drive_scale,
    output logic signed [7:0]      north_offset_factor
);
    gesture_engine_pkg::gest_state_t state_q;
    logic [1:0]  exit_persistence_q;
    logic [7:0]  wait_cfg_q, north_crosstalk_offset_q, proximity_entry_threshold_q, offset_q;
    logic        gesture_enable_q, cycle_start_q;
    logic [2:0]  end_cnt_q, end_cnt_d;
    logic [6:0]  led_tail_q;
    logic [3:0]  gain_q, led_scale_q;
    logic        aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
    logic [7:0]  aw_addr_q;
    logic [31:0] w_data_q, rdata_q, rd_word;
    logic [3:0]  w_strb_q;
    logic [1:0]  bresp_q, rresp_q;
    logic        wr_fire, enter_ok, end_hit, exit_now;
    logic        timer_start, timer_busy, timer_done;
    logic        enter_always;
    logic [2:0]  cycle_wait_time;
    localparam logic [6:0] LED_TAIL = 7'(`LED_TAIL_CYC);
    function automatic logic addr_known(input logic [7:0] a);
        if (a == `ADDR_EXIT_PERS) begin
            addr_known = 1'b1;
        end else if (a == `ADDR_WAIT_CFG) begin
            addr_known = 1'b1;
        end else if (a == `ADDR_NORTH_OFS) begin
            addr_known = 1'b1;
        end else if (a == `ADDR_CONTROL) begin
            addr_known = 1'b1;
        end else if (a == `ADDR_STATUS) begin
            addr_known = 1'b1;
        end else begin
            addr_known = 1'b0;
        end
    endfunction : addr_known
    function automatic logic [2:0] exit_target(input logic [1:0] p);
        case (p)
            2'h0: exit_target = 3'h1;
            2'h1: exit_target = 3'h2;
            2'h2: exit_target = 3'h4;
            default: exit_target = 3'h7;
        endcase
    endfunction : exit_target
    function automatic logic [7:0] sm_to_tc(input logic [7:0] v);
        // Negative zero maps to plain zero
        sm_to_tc = v[7] ? 8'(-{1'b0, v[6:0]}) : {1'b0, v[6:0]};
    endfunction : sm_to_tc
    assign enter_always    = wait_cfg_q[`ENTER_ALWAYS_BIT];
    assign cycle_wait_time = wait_cfg_q[`WAIT_MSB:`WAIT_LSB];
    // AXI write channel: address and data taken in either order
    assign awready = !aw_hold_q && !bvalid_q;
    assign wready  = !w_hold_q && !bvalid_q;
    assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
    assign bvalid  = bvalid_q;
    assign bresp   = bresp_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_hold_q  <= 1'b0;
            w_data_q  <= 32'h0;
            w_strb_q  <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_hold_q <= 1'b1;
                aw_addr_q <= awaddr;
            end else if (wr_fire) begin
                aw_hold_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_hold_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (wr_fire) begin
                w_hold_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= addr_known(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bready) begin
            bvalid_q <= 1'b0;
        end
    end
    // Register writes; the status word ignores writes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            exit_persistence_q          <= `RST_EXIT_PERS;
            wait_cfg_q                  <= `RST_WAIT_CFG;
            north_crosstalk_offset_q    <= `RST_NORTH_OFS;
            gesture_enable_q            <= 1'b0;
            proximity_entry_threshold_q <= `RST_THRESHOLD;
        end else if (wr_fire) begin
            if (aw_addr_q == `ADDR_EXIT_PERS) begin
                if (w_strb_q[0]) begin
                    exit_persistence_q <= w_data_q[`EXIT_PERS_MSB:`EXIT_PERS_LSB];
                end
            end else if (aw_addr_q == `ADDR_WAIT_CFG) begin
                if (w_strb_q[0]) begin
                    wait_cfg_q <= w_data_q[7:0];
                end
            end else if (aw_addr_q == `ADDR_NORTH_OFS) begin
                if (w_strb_q[0]) begin
                    north_crosstalk_offset_q <= w_data_q[7:0];
                end
            end else if (aw_addr_q == `ADDR_CONTROL) begin
                if (w_strb_q[0]) begin
                    gesture_enable_q <= w_data_q[`CTRL_EN_BIT];
                end
                if (w_strb_q[1]) begin
                    proximity_entry_threshold_q <= w_data_q[`CTRL_THR_MSB:`CTRL_THR_LSB];
                end
            end
        end
    end
    // AXI read channel, one cycle latency
    assign arready = !rvalid_q;
    assign rvalid  = rvalid_q;
    assign rdata   = rdata_q;
    assign rresp   = rresp_q;
    always_comb begin
        rd_word = 32'h0;
        if (araddr == `ADDR_EXIT_PERS) begin
            rd_word[`EXIT_PERS_MSB:`EXIT_PERS_LSB] = exit_persistence_q;
        end else if (araddr == `ADDR_WAIT_CFG) begin
            rd_word[7:0] = wait_cfg_q;
        end else if (araddr == `ADDR_NORTH_OFS) begin
            rd_word[7:0] = north_crosstalk_offset_q;
        end else if (araddr == `ADDR_CONTROL) begin
            rd_word[`CTRL_EN_BIT] = gesture_enable_q;
            rd_word[`CTRL_THR_MSB:`CTRL_THR_LSB] = proximity_entry_threshold_q;
        end else if (araddr == `ADDR_STATUS) begin
            rd_word[2:0] = state_q;
            rd_word[6:4] = end_cnt_q;
            rd_word[7]   = timer_busy;
            rd_word[8]   = led_on;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0;
            rresp_q  <= `RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= addr_known(araddr) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (rready) begin
            rvalid_q <= 1'b0;
        end
    end
    assign enter_ok = gesture_enable_q && prox_valid
                   && (enter_always // [R03]
                   || proximity_result >= proximity_entry_threshold_q); // [R04]
    assign end_hit   = cycle_done && gesture_end_det;
    assign end_cnt_d = (end_cnt_q == 3'h7) ? end_cnt_q : end_cnt_q + 3'h1;
    assign exit_now  = end_hit && (end_cnt_d >= exit_target(exit_persistence_q)); // [R01]
    assign timer_start = (state_q == gesture_engine_pkg::ST_CYCLE) && cycle_done && !exit_now;
    always_ff @(posedge aclk) begin
        if (!aresetn || !gesture_enable_q) begin
            state_q       <= gesture_engine_pkg::ST_IDLE;
            cycle_start_q <= 1'b0;
        end else begin
            cycle_start_q <= 1'b0;
            case (state_q)
                gesture_engine_pkg::ST_IDLE: begin
                    if (enter_ok) begin
                        state_q       <= gesture_engine_pkg::ST_CYCLE;
                        cycle_start_q <= 1'b1;
                    end
                end
                gesture_engine_pkg::ST_CYCLE: begin
                    if (exit_now) begin
                        state_q <= gesture_engine_pkg::ST_IDLE; // [R01]
                    end else if (timer_start && timer_done) begin
                        cycle_start_q <= 1'b1;
                    end else if (timer_start) begin
                        state_q <= gesture_engine_pkg::ST_WAIT; // [R07]
                    end
                end
                gesture_engine_pkg::ST_WAIT: begin
                    if (timer_done) begin
                        state_q       <= gesture_engine_pkg::ST_CYCLE;
                        cycle_start_q <= 1'b1;
                    end
                end
                default: begin
                    state_q <= gesture_engine_pkg::ST_IDLE;
                end
            endcase
        end
    end
    // Consecutive gesture-end counter
    always_ff @(posedge aclk) begin
        if (!aresetn || state_q != gesture_engine_pkg::ST_CYCLE) begin
            end_cnt_q <= 3'h0;
        end else if (exit_now) begin
            end_cnt_q <= 3'h0;
        end else if (end_hit) begin
            end_cnt_q <= end_cnt_d; // [R01]
        end else if (cycle_done) begin
            end_cnt_q <= 3'h0; // [R02]
        end
    end
    // Wait time is sampled at each wait start, so a late change only affects later cycles
    gesture_wait_timer #(
        .UNIT_CYCLES (WAIT_UNIT_CYCLES)
    ) u_wait (
        .aclk    (aclk),
        .aresetn (aresetn),
        .start   (timer_start),
        .code    (cycle_wait_time), // [R07] [R08]
        .busy    (timer_busy),
        .done    (timer_done)
    );
    // LED tail past the integration window
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            led_tail_q <= 7'h0;
        end else if (integration_active) begin
            led_tail_q <= LED_TAIL; // [R09]
        end else if (led_tail_q != 7'h0) begin
            led_tail_q <= led_tail_q - 7'h1;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gain_q      <= 4'h1;
            led_scale_q <= 4'h8;
            offset_q    <= 8'h00;
        end else begin
            gain_q      <= 4'h1 << wait_cfg_q[`GAIN_MSB:`GAIN_LSB]; // [R05]
            led_scale_q <= 4'h8 >> wait_cfg_q[`LED_MSB:`LED_LSB]; // [R06]
            offset_q    <= sm_to_tc(north_crosstalk_offset_q); // [R10]
        end
    end
    assign in_gesture          = (state_q != gesture_engine_pkg::ST_IDLE);
    assign cycle_start         = cycle_start_q;
    assign wait_active         = (state_q == gesture_engine_pkg::ST_WAIT);
    assign led_on              = (led_tail_q != 7'h0);
    assign photodiode_gain     = gain_q;
    assign led_drive_scale     = led_scale_q;
    assign north_offset_factor = offset_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_exit_count: assert property ( // [R01]
        (state_q == gesture_engine_pkg::ST_CYCLE && gesture_enable_q && end_hit
         && end_cnt_q + 3'h1 >= exit_target(exit_persistence_q))
        |=> state_q == gesture_engine_pkg::ST_IDLE)
        else $error("gesture did not exit at persistence count");
    a_no_early_exit: assert property ( // [R01]
        (state_q == gesture_engine_pkg::ST_CYCLE && gesture_enable_q && cycle_done
         && (!gesture_end_det || end_cnt_q + 3'h1 < exit_target(exit_persistence_q)))
        |=> state_q != gesture_engine_pkg::ST_IDLE)
        else $error("gesture exited early");
    a_count_clear: assert property ( // [R02]
        (state_q == gesture_engine_pkg::ST_CYCLE && cycle_done && !gesture_end_det)
        |=> end_cnt_q == 3'h0)
        else $error("end count not cleared");
    a_enter_always: assert property ( // [R03]
        (state_q == gesture_engine_pkg::ST_IDLE && gesture_enable_q && prox_valid && enter_always)
        |=> state_q == gesture_engine_pkg::ST_CYCLE && cycle_start)
        else $error("enter-always did not enter");
    a_enter_thresh: assert property ( // [R04]
        (state_q == gesture_engine_pkg::ST_IDLE && prox_valid && !enter_always
         && proximity_result < proximity_entry_threshold_q)
        |=> state_q == gesture_engine_pkg::ST_IDLE)
        else $error("entered below threshold");
    a_gain_decode: assert property ( // [R05]
        photodiode_gain == (4'h1 << $past(wait_cfg_q[`GAIN_MSB:`GAIN_LSB])))
        else $error("gain decode wrong");
    a_led_scale: assert property ( // [R06]
        led_drive_scale == (4'h8 >> $past(wait_cfg_q[`LED_MSB:`LED_LSB])))
        else $error("LED scale decode wrong");
    a_zero_wait: assert property ( // [R07]
        (timer_start && cycle_wait_time == 3'h0 && gesture_enable_q)
        |=> state_q == gesture_engine_pkg::ST_CYCLE && cycle_start)
        else $error("zero wait did not restart at once");
    a_led_tail: assert property ( // [R09]
        $fell(integration_active) |-> led_on && led_tail_q == LED_TAIL)
        else $error("LED tail not loaded");
    a_led_ends: assert property ( // [R09]
        (led_tail_q == 7'h1 && !integration_active) |=> !led_on)
        else $error("LED tail too long");
    a_offset_sign: assert property ( // [R10]
        north_offset_factor == signed'(sm_to_tc($past(north_crosstalk_offset_q))))
        else $error("offset factor wrong");
    c_enter: cover property (state_q == gesture_engine_pkg::ST_IDLE ##1 state_q == gesture_engine_pkg::ST_CYCLE);
    c_wait: cover property (state_q == gesture_engine_pkg::ST_WAIT ##1 state_q == gesture_engine_pkg::ST_CYCLE);
    c_exit7: cover property (exit_now && exit_persistence_q == 2'h3);
endmodule : gesture_engine_config

/* tb/gesture_engine_config_tb.sv */
// Self-checking bench for the gesture configuration block
`timescale 1ns/1ps
`include "gesture_engine_defines.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module gesture_engine_config_tb;
    localparam int UNIT = 4;
    logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
    logic [7:0]  awaddr, araddr, proximity_result;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb, photodiode_gain, led_drive_scale;
    logic [1:0]  bresp, rresp, rsp;
    logic        prox_valid, cycle_done, gesture_end_det, integration_active;
    logic        in_gesture, cycle_start, wait_active, led_on;
    logic signed [7:0] north_offset_factor;
    logic [31:0] rd;
    int          fails, cmp_count, cnt;
    int          need[4] = '{1, 2, 4, 7};
    int          units[8] = '{0, 1, 2, 3, 5, 8, 11, 14};
    logic [7:0]  ofs_in[7] = '{8'h7F, 8'h01, 8'h00, 8'h81, 8'h82, 8'hFF, 8'h80};
    logic [7:0]  ofs_exp[7] = '{8'h7F, 8'h01, 8'h00, 8'hFF, 8'hFE, 8'h81, 8'h00};

    gesture_engine_config #(.WAIT_UNIT_CYCLES(UNIT)) dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .proximity_result(proximity_result),
        .prox_valid(prox_valid), .cycle_done(cycle_done), .gesture_end_det(gesture_end_det),
        .integration_active(integration_active), .in_gesture(in_gesture), .cycle_start(cycle_start),
        .wait_active(wait_active), .led_on(led_on), .photodiode_gain(photodiode_gain),
        .led_drive_scale(led_drive_scale), .north_offset_factor(north_offset_factor));

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    // Ready is sampled 1 ns after each edge, when it has settled for the next edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb, done;
        logic [1:0] rs;
        done = 1'b0;
        @(posedge aclk);
        awaddr <= a; awvalid <= 1'b1; wdata <= d; wstrb <= 4'hF; wvalid <= 1'b1; bready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            #1;
            ta = awvalid && awready; tw = wvalid && wready; tb = bvalid && bready; rs = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            if (tb) begin
                bready <= 1'b0; r = rs; done = 1'b1;
            end
        end
        if (!done) fails++;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr, done;
        done = 1'b0;
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        for (int n = 0; n < 50 && !done; n++) begin
            #1;
            ta = arvalid && arready; tr = rvalid && rready; d = rdata; r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
            if (tr) begin
                rready <= 1'b0; done = 1'b1;
            end
        end
        if (!done) fails++;
    endtask : axi_rd

    task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
        axi_wr(a, d, rsp);
        // Let the registered outputs launched at the final edge settle
        #1;
        `CHK("bresp", `RESP_OKAY, rsp)
    endtask : wr_ok

    task automatic enter(input logic [7:0] p);
        @(posedge aclk);
        prox_valid <= 1'b1; proximity_result <= p;
        @(posedge aclk);
        prox_valid <= 1'b0;
        #1;
    endtask : enter

    task automatic pulse(input logic e);
        @(posedge aclk);
        cycle_done <= 1'b1; gesture_end_det <= e;
        @(posedge aclk);
        cycle_done <= 1'b0;
        repeat (3) @(posedge aclk);
        #1;
    endtask : pulse

    // Config is always written with the engine disabled, as software is told to
    task automatic setup(input logic [1:0] pers, input logic [7:0] cfg, input logic [7:0] thr);
        wr_ok(`ADDR_CONTROL, 32'h0000_0000);
        wr_ok(`ADDR_EXIT_PERS, {30'h0, pers});
        wr_ok(`ADDR_WAIT_CFG, {24'h0, cfg});
        wr_ok(`ADDR_CONTROL, {16'h0, thr, 8'h01});
    endtask : setup

    task automatic stop_test;
        if (fails == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        #1_000_000;
        fails++;
        stop_test();
    end

    initial begin
        aresetn = 1'b0; awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0; proximity_result = 8'h00;
        prox_valid = 1'b0; cycle_done = 1'b0; gesture_end_det = 1'b0; integration_active = 1'b0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        #1;
        `CHK("gain_rst", 4'h1, photodiode_gain)
        `CHK("scale_rst", 4'h8, led_drive_scale)
        foreach (ofs_in[i]) begin
            wr_ok(`ADDR_NORTH_OFS, {24'h0, ofs_in[i]});
            `CHK("north_ofs", ofs_exp[i], north_offset_factor)
        end
        for (int g = 0; g < 4; g++) begin
            wr_ok(`ADDR_WAIT_CFG, {24'h0, 1'b0, g[1:0], g[1:0], 3'h5});
            `CHK("gain", 4'h1 << g, photodiode_gain)
            `CHK("scale", 4'h8 >> g, led_drive_scale)
        end
        axi_rd(`ADDR_WAIT_CFG, rd, rsp);
        `CHK("cfg_rd", 32'h0000_007D, rd)
        wr_ok(`ADDR_EXIT_PERS, 32'hFFFF_FFFF);
        axi_rd(`ADDR_EXIT_PERS, rd, rsp);
        `CHK("pers_rd", 32'h0000_0003, rd)
        axi_wr(8'h3C, 32'h1234_5678, rsp);
        `CHK("bad_wr", `RESP_SLVERR, rsp)
        axi_rd(8'h3C, rd, rsp);
        `CHK("bad_rresp", `RESP_SLVERR, rsp)
        `CHK("bad_rdata", 32'h0, rd)
        wr_ok(`ADDR_STATUS, 32'hFFFF_FFFF);
        axi_rd(`ADDR_STATUS, rd, rsp);
        `CHK("status_idle", 3'h1, rd[2:0])
        // Threshold boundary: one below refused, equal accepted
        setup(2'h0, 8'h00, 8'h40);
        enter(8'h3F);
        `CHK("below_thr", 1'b0, in_gesture)
        enter(8'h40);
        `CHK("at_thr", 1'b1, in_gesture)
        `CHK("start_thr", 1'b1, cycle_start)
        wr_ok(`ADDR_CONTROL, 32'h0000_0000);
        `CHK("disabled", 1'b0, in_gesture)
        for (int p = 0; p < 4; p++) begin
            setup(p[1:0], 8'h80, 8'hFF);
            enter(8'h00);
            `CHK("enter_zero", 1'b1, in_gesture)
            repeat (need[p] - 1) pulse(1'b1);
            `CHK("not_yet", 1'b1, in_gesture)
            pulse(1'b1);
            `CHK("exited", 1'b0, in_gesture)
        end
        // A single non-end cycle must restart the count
        setup(2'h2, 8'h80, 8'hFF);
        enter(8'h00);
        repeat (3) pulse(1'b1);
        pulse(1'b0);
        repeat (3) pulse(1'b1);
        `CHK("run_broken", 1'b1, in_gesture)
        pulse(1'b1);
        `CHK("run_exit", 1'b0, in_gesture)
        for (int c = 0; c < 8; c++) begin
            setup(2'h3, {5'h10, c[2:0]}, 8'hFF);
            enter(8'h00);
            @(posedge aclk);
            cycle_done <= 1'b1; gesture_end_det <= 1'b0;
            @(posedge aclk);
            cycle_done <= 1'b0;
            cnt = 0;
            for (int i = 0; i < 100; i++) begin
                #1;
                if (cycle_start) break;
                if (wait_active) cnt++;
                @(posedge aclk);
            end
            `CHK("wait_cycles", units[c] * UNIT, cnt)
            `CHK("wait_back", 1'b1, in_gesture)
        end
        @(posedge aclk);
        integration_active <= 1'b1;
        @(posedge aclk);
        #1;
        `CHK("led_rise", 1'b1, led_on)
        repeat (5) @(posedge aclk);
        integration_active <= 1'b0;
        cnt = 0;
        for (int i = 0; i < 200; i++) begin
            #1;
            if (!led_on) break;
            cnt++;
            @(posedge aclk);
        end
        `CHK("led_tail", `LED_TAIL_CYC, cnt)
        stop_test();
    end
endmodule : gesture_engine_config_tb
